// file: logic/adc_power_mode_and_config_loader.sv
// Mode, power-down and serial configuration control for a dual converter.
//
// Notes on behaviour
// - Pin mode, code 000 powers everything off.
// - Decode power code into three enable groups.
// - Code 111 resets only in pin mode.
// - Reset clears registers, everything stays powered down.
// - Gain inputs pick mode; registers start zero.
// - Register mode starts off, gain one, awaiting write.
// - Register mode uses bit zero as data.
// - Sample data on falling clock, select low.
// - Four address, twelve data, commit seventeenth edge.
// - Load only twelve bits after address.
// - New setting applies to following conversion.
// - Word shifted MSB first, zero after power-up.
// - Word sets gain, power, calibration, read-back.
// - Any gain input high selects pin mode.
// - Target address 0001 selects configuration word.
// - Fields: 11-8 read, 7 cal, 6-4 power, 3-0 gain.
`timescale 1ns/1ps

module adc_power_mode_and_config_loader (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic                          sclk,
  input  wire logic                          cs_n,
  input  wire logic                          pwr_sel_bit0_serial_in,
  input  wire logic                          pwr_sel_bit1,
  input  wire logic                          pwr_sel_bit2,
  input  wire logic [3:0]                    gain_select_inputs,
  output      adc_cfg_pkg::pwr_enables_type  pwr_enables,
  output      logic [3:0]                    gain_code,
  output      logic                          cal_start,
  output      logic [3:0]                    readback_select_bits,
  output      adc_cfg_pkg::mode_type         op_mode,
  output      logic [adc_cfg_pkg::CFG_W-1:0] configuration_word
);
  import adc_cfg_pkg::*;

  // ==========================================================================
  // Power-down code decode
  // ==========================================================================

  // Turns a three-bit power-down code into the three enable groups.
  function automatic pwr_enables_type pwr_decode(input logic [2:0] code);
    pwr_enables_type p;
    p = pwr_enables_type'(3'h0);
    case (code)
      3'h0: p = pwr_enables_type'(3'h0);
      3'h1: p = pwr_enables_type'(3'h1);
      3'h2: p = pwr_enables_type'(3'h2);
      3'h3: p = pwr_enables_type'(3'h4);
      3'h4: p = pwr_enables_type'(3'h6);
      3'h5: p = pwr_enables_type'(3'h7);
      default: p = pwr_enables_type'(3'h0);
    endcase
    return p;
  endfunction

  // ==========================================================================
  // Link side, clocked on the falling serial clock
  // ==========================================================================
  logic [CNT_W-1:0]      edge_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [CFG_W-1:0]      word_l_q;
  logic                  tog_l_q;
  logic                  commit_edge;

  // The seventeenth falling edge of a frame carries the commit.
  assign commit_edge = (edge_cnt_q == DATA_END);

  // Counts falling edges of a frame; chip select high holds it at zero, so
  // a frame cut short starts over from the first address bit.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      edge_cnt_q <= CNT_ZERO;
    end else if (edge_cnt_q != FRAME_EDGES) begin
      edge_cnt_q <= edge_cnt_q + CNT_ONE;
    end
  end

  // Shifts the data pin in, MSB first, for the first sixteen edges only.
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= SHIFT_RESET;
    end else if (!cs_n && (edge_cnt_q < DATA_END)) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], pwr_sel_bit0_serial_in};
    end
  end

  // Commits the twelve data bits when the address names the configuration
  // word; later edges of the same frame leave the held word alone.
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      word_l_q <= CFG_RESET;
      tog_l_q  <= 1'b0;
    end else if (!cs_n && commit_edge &&
                 shift_q[FRAME_BITS-1:CFG_W] == WR_TARGET_CFG) begin
      word_l_q <= shift_q[CFG_W-1:0];
      tog_l_q  <= ~tog_l_q;
    end
  end

  // ==========================================================================
  // Crossing into the main clock
  // ==========================================================================
  pin_state_type pins_raw;
  pin_state_type pins_s1_q;
  pin_state_type pins_s2_q;
  logic          tog_s1_q;
  logic          tog_s2_q;
  logic          tog_s3_q;
  logic          commit_evt;
  logic          pin_mode;
  logic          pin_reset;

  assign pins_raw = {gain_select_inputs, pwr_sel_bit2, pwr_sel_bit1,
                     pwr_sel_bit0_serial_in};

  // Two-stage synchronisers for the mode and power-down pins.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pins_s1_q <= PINS_RESET;
      pins_s2_q <= PINS_RESET;
    end else begin
      pins_s1_q <= pins_raw;
      pins_s2_q <= pins_s1_q;
    end
  end

  // The commit toggle is synchronised and then edge-detected; the held
  // word is stable for many main clocks after each toggle.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      tog_s1_q <= tog_l_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // Mode and pin reset are derived from the synchronised pins only.
  assign commit_evt = tog_s2_q ^ tog_s3_q;
  assign pin_mode   = (pins_s2_q.gain_select_inputs != GAIN_SW_CTRL);
  assign pin_reset  = pin_mode && (pins_s2_q.pwr_sel == PD_RESET_CMD);

  // ==========================================================================
  // Configuration word and outputs
  // ==========================================================================
  logic [CFG_W-1:0] cfg_q;
  pwr_enables_type  pwr_q;
  logic [3:0]       gain_q;
  logic             cal_q;
  logic [3:0]       rd_q;
  mode_type         mode_q;

  // Holds the configuration word; a pin reset clears it, and a committed
  // frame replaces it only in register mode.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= CFG_RESET;
    end else if (pin_reset) begin
      cfg_q <= CFG_RESET;
    end else if (commit_evt && !pin_mode) begin
      cfg_q <= word_l_q;
    end
  end

  // Tracks the operating mode from the gain-select inputs.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= MODE_PIN;
    end else begin
      mode_q <= pin_mode ? MODE_PIN : MODE_REG;
    end
  end

  // Power enables come from the pins in pin mode, else from the word.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pwr_q <= pwr_enables_type'(3'h0);
    end else if (pin_mode) begin
      pwr_q <= pwr_decode(pins_s2_q.pwr_sel);
    end else begin
      pwr_q <= pwr_decode(cfg_q[PD_HI:PD_LO]);
    end
  end

  // A zero gain field in register mode means unity gain.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      gain_q <= GAIN_X1;
    end else if (pin_mode) begin
      gain_q <= pins_s2_q.gain_select_inputs;
    end else if (cfg_q[GAIN_HI:GAIN_LO] == GAIN_SW_CTRL) begin
      gain_q <= GAIN_X1;
    end else begin
      gain_q <= cfg_q[GAIN_HI:GAIN_LO];
    end
  end

  // Calibration start and read-back select only act in register mode.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cal_q <= 1'b0;
      rd_q  <= RD_RESULT;
    end else if (pin_mode) begin
      cal_q <= 1'b0;
      rd_q  <= RD_RESULT;
    end else begin
      cal_q <= cfg_q[CAL_BIT];
      rd_q  <= cfg_q[RD_HI:RD_LO];
    end
  end

  assign pwr_enables          = pwr_q;
  assign gain_code            = gain_q;
  assign cal_start            = cal_q;
  assign readback_select_bits = rd_q;
  assign op_mode              = mode_q;
  assign configuration_word   = cfg_q;

  // ==========================================================================
  // Checks
  // ==========================================================================

  // Code 000 in pin mode leaves everything off one clock later.
  AST_PIN_ALL_OFF: assert property (
    @(posedge mclk) disable iff (!resetn)
    (pin_mode && pins_s2_q.pwr_sel == PD_ALL_OFF) |=>
      (pwr_enables == pwr_enables_type'(3'h0)))
    else $error("Code 000 in pin mode left a block powered.");

  // Code 011 in pin mode powers only the low-power comparator pair.
  AST_DECODE_AB: assert property (
    @(posedge mclk) disable iff (!resetn)
    (pin_mode && pins_s2_q.pwr_sel == 3'h3) |=>
      (pwr_enables.comp_ab && !pwr_enables.comp_cd && !pwr_enables.adc))
    else $error("Code 011 did not power only the A and B pair.");

  // Code 101 in pin mode powers all three groups.
  AST_DECODE_ALL_ON: assert property (
    @(posedge mclk) disable iff (!resetn)
    (pin_mode && pins_s2_q.pwr_sel == PD_ALL_ON) |=>
      (pwr_enables == pwr_enables_type'(3'h7)))
    else $error("Code 101 did not power every block.");

  // The all-ones code in pin mode clears the word and powers down.
  AST_PIN_RESET: assert property (
    @(posedge mclk) disable iff (!resetn)
    pin_reset |=> (configuration_word == CFG_RESET)
      ##1 (pwr_enables == pwr_enables_type'(3'h0) || !pin_reset))
    else $error("Pin reset did not clear the configuration.");

  // In register mode the all-ones pin code does not disturb the word.
  AST_REG_NO_RESET: assert property (
    @(posedge mclk) disable iff (!resetn)
    (!pin_mode && pins_s2_q.pwr_sel == PD_RESET_CMD && !commit_evt) |=>
      $stable(configuration_word))
    else $error("Register mode word changed without a commit.");

  // The mode output follows the synchronised gain-select inputs one clock later.
  AST_MODE_SELECT: assert property (
    @(posedge mclk) disable iff (!resetn)
    resetn |=> (op_mode == ($past(pin_mode) ? MODE_PIN : MODE_REG)))
    else $error("Operating mode does not follow the gain inputs.");

  // The word moves only on a commit in register mode or a pin reset.
  AST_COMMIT_ONLY: assert property (
    @(posedge mclk) disable iff (!resetn)
    (!pin_reset && !(commit_evt && !pin_mode)) |=>
      $stable(configuration_word))
    else $error("Configuration word changed outside a commit.");

  // A zero word in register mode keeps all off at unity gain.
  AST_REG_DEFAULT: assert property (
    @(posedge mclk) disable iff (!resetn)
    (!pin_mode && configuration_word == CFG_RESET) |=>
      (pwr_enables == pwr_enables_type'(3'h0) && gain_code == GAIN_X1))
    else $error("Zero register word did not give off and unity gain.");

  // A commit edge with the configuration address loads the data bits.
  AST_LINK_LOAD: assert property (
    @(negedge sclk) disable iff (!resetn || cs_n)
    (commit_edge && shift_q[FRAME_BITS-1:CFG_W] == WR_TARGET_CFG) |=>
      (word_l_q == $past(shift_q[CFG_W-1:0])) && (tog_l_q != $past(tog_l_q)))
    else $error("Committed frame did not load the held word.");

  // Edges past the commit neither shift nor change the held word.
  AST_LINK_IGNORE: assert property (
    @(negedge sclk) disable iff (!resetn || cs_n)
    (edge_cnt_q == FRAME_EDGES) |=> ($stable(word_l_q) && $stable(shift_q)))
    else $error("Bits after the frame altered the held word.");

  // Any other target address leaves the held word unchanged.
  AST_LINK_ADDR: assert property (
    @(negedge sclk) disable iff (!resetn || cs_n)
    (commit_edge && shift_q[FRAME_BITS-1:CFG_W] != WR_TARGET_CFG) |=>
      $stable(word_l_q))
    else $error("A frame for another target loaded the word.");

  // Code 001 in pin mode powers only the converter pair.
  AST_DECODE_ADC: assert property (
    @(posedge mclk) disable iff (!resetn)
    (pin_mode && pins_s2_q.pwr_sel == 3'h1) |=>
      (!pwr_enables.comp_ab && !pwr_enables.comp_cd && pwr_enables.adc))
    else $error("Code 001 did not power only the converters.");

  // Code 010 in pin mode powers only the fast comparator pair.
  AST_DECODE_CD: assert property (
    @(posedge mclk) disable iff (!resetn)
    (pin_mode && pins_s2_q.pwr_sel == 3'h2) |=>
      (!pwr_enables.comp_ab && pwr_enables.comp_cd && !pwr_enables.adc))
    else $error("Code 010 did not power only the C and D pair.");

  // Code 100 in pin mode powers both comparator pairs, no converters.
  AST_DECODE_COMPS: assert property (
    @(posedge mclk) disable iff (!resetn)
    (pin_mode && pins_s2_q.pwr_sel == 3'h4) |=>
      (pwr_enables.comp_ab && pwr_enables.comp_cd && !pwr_enables.adc))
    else $error("Code 100 did not power only the comparators.");

  // A word holding code 101 in register mode powers every block.
  AST_REG_POWER: assert property (
    @(posedge mclk) disable iff (!resetn)
    (!pin_mode && configuration_word[PD_HI:PD_LO] == PD_ALL_ON) |=>
      (pwr_enables == pwr_enables_type'(3'h7)))
    else $error("Register code 101 did not power every block.");

  // Calibration and read-back outputs follow their word fields.
  AST_REG_FIELDS: assert property (
    @(posedge mclk) disable iff (!resetn)
    (!pin_mode) |=> (cal_start == $past(configuration_word[CAL_BIT]) &&
      readback_select_bits == $past(configuration_word[RD_HI:RD_LO])))
    else $error("Calibration or read-back output missed its field.");

endmodule

// file: shared/adc_cfg_pkg.sv
// Constants and types shared by the converter mode and configuration loader.
package adc_cfg_pkg;

  // ==========================================================================
  // Configuration word layout
  // ==========================================================================
  localparam int CFG_W     = 12;
  localparam int RD_HI     = 11;
  localparam int RD_LO     = 8;
  localparam int CAL_BIT   = 7;
  localparam int PD_HI     = 6;
  localparam int PD_LO     = 4;
  localparam int GAIN_HI   = 3;
  localparam int GAIN_LO   = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;

  // ==========================================================================
  // Serial frame shape
  // ==========================================================================
  localparam int ADDR_BITS  = 4;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W      = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE     = 5'h01;
  localparam logic [CNT_W-1:0] DATA_END    = 5'h10;
  localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h11;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
  localparam logic [ADDR_BITS-1:0]  WR_TARGET_CFG = 4'h1;

  // ==========================================================================
  // Codes
  // ==========================================================================
  localparam logic [2:0] PD_ALL_OFF   = 3'h0;
  localparam logic [2:0] PD_ALL_ON    = 3'h5;
  localparam logic [2:0] PD_RESET_CMD = 3'h7;
  localparam logic [3:0] GAIN_SW_CTRL = 4'h0;
  localparam logic [3:0] GAIN_X1      = 4'h1;
  localparam logic [3:0] RD_RESULT    = 4'h0;

  // Power enables for the comparator pairs and the converter pair.
  typedef struct packed {
    logic comp_ab;
    logic comp_cd;
    logic adc;
  } pwr_enables_type;

  // Synchronised mode and power-down pins.
  typedef struct packed {
    logic [3:0] gain_select_inputs;
    logic [2:0] pwr_sel;
  } pin_state_type;

  localparam pin_state_type PINS_RESET = 7'h00;

  // Operating mode chosen by the gain-select inputs.
  typedef enum logic {
    MODE_PIN = 1'b0,
    MODE_REG = 1'b1
  } mode_type;

endpackage

// file: verif/host_serial_model.sv
// Host serial port model that writes framed words into the loader.
`timescale 1ns/1ps

module host_serial_model (
  output logic sclk,
  output logic cs_n,
  output logic sdata
);
  // ==========================================================================
  // Frame timing
  // ==========================================================================
  localparam realtime HALF = 80.0;

  // The link clock idles high and stands still between frames; chip select
  // rises just after time zero so the link counter sees a clean clear edge.
  initial begin
    sclk = 1'b1;
    sdata = 1'b0;
    #1;
    cs_n = 1'b1;
  end

  // Sends one frame of the given number of falling edges.
  task automatic send(input logic [3:0] addr, input logic [11:0] word,
                      input int edges);
    logic [15:0] bits;
    bits = {addr, word};
    #7.3;
    cs_n = 1'b0;
    for (int i = 0; i < edges; i++) begin
      sdata = (i < 16) ? bits[15-i] : ~sdata;
      #(HALF);
      sclk = 1'b0;
      #(HALF);
      sclk = 1'b1;
    end
    #(HALF);
    cs_n = 1'b1;
    sdata = ~sdata;
  endtask
endmodule

// file: verif/test_adc_power_mode_and_config_loader.sv
// Self-checking bench for the converter mode and configuration loader.
`timescale 1ns/1ps

module test_adc_power_mode_and_config_loader;
  import adc_cfg_pkg::*;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic               mclk;
  logic               resetn;
  logic               sclk;
  logic               cs_n;
  logic               host_data;
  logic               pd0_q;
  logic               pd1_q;
  logic               pd2_q;
  logic               link_sel_q;
  logic [3:0]         gain_q;
  pwr_enables_type    en;
  logic [3:0]         gain_code;
  logic [3:0]         rd_sel;
  logic               cal;
  mode_type           mode;
  logic [CFG_W-1:0]   cfg;
  logic               din;
  int                 err_total;
  int                 compares;
  int                 cycles;

  `define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin \
    err_total++; $display("CHECK FAILED %0t %s", $time, m); end end

  // The shared pin carries the host's data only in register mode.
  assign din = link_sel_q ? host_data : pd0_q;

  adc_power_mode_and_config_loader adc_power_mode_and_config_loader_inst (
    .mclk                   (mclk),
    .resetn                 (resetn),
    .sclk                   (sclk),
    .cs_n                   (cs_n),
    .pwr_sel_bit0_serial_in (din),
    .pwr_sel_bit1           (pd1_q),
    .pwr_sel_bit2           (pd2_q),
    .gain_select_inputs     (gain_q),
    .pwr_enables            (en),
    .gain_code              (gain_code),
    .cal_start              (cal),
    .readback_select_bits   (rd_sel),
    .op_mode                (mode),
    .configuration_word     (cfg)
  );

  host_serial_model host_serial_model_inst (
    .sclk  (sclk),
    .cs_n  (cs_n),
    .sdata (host_data)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Expected enables {comp_ab, comp_cd, adc} for a power code.
  function automatic logic [2:0] exp_en(input logic [2:0] c);
    case (c)
      3'h1: return 3'b001;
      3'h2: return 3'b010;
      3'h3: return 3'b100;
      3'h4: return 3'b110;
      3'h5: return 3'b111;
      default: return 3'b000;
    endcase
  endfunction

  // Drives the mode and power pins, then waits past the sync stages.
  task automatic pins(input logic [3:0] g, input logic [2:0] pd);
    @(posedge mclk);
    gain_q <= g;
    {pd2_q, pd1_q, pd0_q} <= pd;
    link_sel_q <= (g == 4'h0);
    repeat (5) @(posedge mclk);
  endtask

  // Sends a frame and waits until the commit has crossed over.
  task automatic frame(input logic [3:0] a, input logic [11:0] w,
                       input int n);
    host_serial_model_inst.send(a, w, n);
    repeat (8) @(posedge mclk);
  endtask

  // Compares all decoded outputs at once.
  task automatic outs(input logic [2:0] e, input logic [3:0] g,
                      input logic c, input logic [3:0] r, input mode_type m);
    `CHK(en, e, "power enables")
    `CHK(gain_code, g, "gain code")
    `CHK(cal, c, "calibration")
    `CHK(rd_sel, r, "read-back select")
    `CHK(mode, m, "mode")
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("Counts: %0d compares, %0d errors", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, timeout and main sequence
  // ==========================================================================
  // The main clock toggles every 12.5 ns, giving a 25 ns period.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // A hung run is cut short and counted as a mismatch.
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 8000) begin
      err_total++;
      close_out();
    end
  end

  // Runs the scenarios in order.
  initial begin
    resetn = 1'b1;
    gain_q = 4'h0;
    {pd2_q, pd1_q, pd0_q} = 3'h0;
    link_sel_q = 1'b1;
    err_total = 0;
    compares = 0;
    cycles = 0;
    // Reset falls on the first edge so every flop sees a clean edge.
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (19) @(posedge mclk);
    `CHK(cfg, CFG_RESET, "reset word")
    `CHK(en, 3'b000, "reset power")
    @(posedge mclk);
    resetn <= 1'b1;
    repeat (600) @(posedge mclk);
    outs(3'b000, GAIN_X1, 1'b0, 4'h0, MODE_REG);
    `CHK(cfg, CFG_RESET, "power-up word")
    frame(WR_TARGET_CFG, 12'h0D3, 17);
    `CHK(cfg, 12'h0D3, "full frame")
    outs(3'b111, 4'h3, 1'b1, 4'h0, MODE_REG);
    frame(WR_TARGET_CFG, 12'hA47, 16);
    `CHK(cfg, 12'h0D3, "short frame")
    frame(4'h2, 12'hA47, 17);
    `CHK(cfg, 12'h0D3, "other target")
    frame(WR_TARGET_CFG, 12'hA47, 20);
    `CHK(cfg, 12'hA47, "extra edges")
    outs(3'b110, 4'h7, 1'b0, 4'hA, MODE_REG);
    frame(WR_TARGET_CFG, 12'h070, 17);
    `CHK(cfg, 12'h070, "no reset in register mode")
    outs(3'b000, GAIN_X1, 1'b0, 4'h0, MODE_REG);
    for (int c = 0; c < 8; c++) begin
      pins(c[0] ? 4'h8 : 4'h2, c[2:0]);
      outs(exp_en(c[2:0]), c[0] ? 4'h8 : 4'h2, 1'b0, 4'h0, MODE_PIN);
      `CHK(cfg, (c == 7) ? CFG_RESET : 12'h070, "pin word")
    end
    pins(4'h0, 3'h0);
    outs(3'b000, GAIN_X1, 1'b0, 4'h0, MODE_REG);
    frame(WR_TARGET_CFG, 12'h050, 17);
    outs(3'b111, GAIN_X1, 1'b0, 4'h0, MODE_REG);
    close_out();
  end
endmodule
